// File: logic/ppl_pkg.sv
package ppl_pkg;

    // ****************************************
    // Bus widths and modes
    // ****************************************
    localparam int          DATA_W      = 32;
    localparam logic [1:0]  WIDTH_X8    = 2'h0;
    localparam logic [1:0]  WIDTH_X16   = 2'h1;
    localparam logic [1:0]  WIDTH_X32   = 2'h2;
    localparam logic [31:0] MASK_X8     = 32'h0000_00ff;
    localparam logic [31:0] MASK_X16    = 32'h0000_ffff;
    localparam logic [31:0] MASK_X32    = 32'hffff_ffff;

    // ****************************************
    // Clock-to-data ratios
    // ****************************************
    localparam logic [3:0]  RATIO_1     = 4'h1;
    localparam logic [3:0]  RATIO_2     = 4'h2;
    localparam logic [3:0]  RATIO_4     = 4'h4;
    localparam logic [3:0]  RATIO_8     = 4'h8;

    // ****************************************
    // Host clock divider
    // ****************************************
    localparam int          CORE_CLK_NS = 50;
    localparam int          CFG_CLK_NS  = 400;
    localparam int          HALF_CYC    = CFG_CLK_NS / (2 * CORE_CLK_NS);
    localparam logic [3:0]  HALF_CNT    = 4'(HALF_CYC);

    // Ratio for a width and feature combination
    function automatic logic [3:0] ratio_of(input logic [1:0] width,
                                            input logic       decomp,
                                            input logic       secure);
        logic [3:0] r;
        r = RATIO_1;
        case (width)
            WIDTH_X8:  r = decomp ? RATIO_2 : RATIO_1;
            WIDTH_X16: r = decomp ? RATIO_4 : (secure ? RATIO_2 : RATIO_1);
            WIDTH_X32: r = decomp ? RATIO_8 : (secure ? RATIO_4 : RATIO_1);
            default:   r = RATIO_1;
        endcase
        return r;
    endfunction

    // Data lanes that carry configuration data
    function automatic logic [31:0] lane_mask(input logic [1:0] width);
        logic [31:0] m;
        m = MASK_X32;
        case (width)
            WIDTH_X8:  m = MASK_X8;
            WIDTH_X16: m = MASK_X16;
            default:   m = MASK_X32;
        endcase
        return m;
    endfunction

endpackage

// File: logic/ppl_if.sv
interface ppl_if;
    logic        config_clock;
    logic [31:0] cfg_data;

    modport host_mp
    (
        output config_clock,
        output cfg_data
    );

    modport device_mp
    (
        input  config_clock,
        input  cfg_data
    );
endinterface

// File: logic/passive_parallel_load_device.sv
module passive_parallel_load_device
    import ppl_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    ppl_if.device_mp         link,
    input  wire logic [1:0]  width_sel_i,
    input  wire logic        decomp_en_i,
    input  wire logic        secure_en_i,
    input  wire logic        start_i,
    output logic [31:0]      word_o,
    output logic             word_valid_o,
    output logic             proc_busy_o
);

    // ****************************************
    // Synchronisers
    // ****************************************
    logic        clk_s1_reg;
    logic        clk_s2_reg;
    logic        clk_s3_reg;
    logic [31:0] dat_s1_reg;
    logic [31:0] dat_s2_reg;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_s3_reg <= 1'b0;
            dat_s1_reg <= 32'h0;
            dat_s2_reg <= 32'h0;
        end
        else
        begin
            clk_s1_reg <= link.config_clock;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            dat_s1_reg <= link.cfg_data;
            dat_s2_reg <= dat_s1_reg;
        end
    end

    logic rise;
    assign rise = clk_s2_reg & ~clk_s3_reg;

    // ****************************************
    // Slot state
    // ****************************************
    logic [3:0]  ratio_reg;
    logic [3:0]  ratio_next;
    logic [1:0]  width_reg;
    logic [1:0]  width_next;
    logic [3:0]  phase_reg;
    logic [3:0]  phase_next;
    logic [31:0] word_reg;
    logic [31:0] word_next;
    logic        valid_reg;
    logic        valid_next;
    logic        busy_reg;
    logic        busy_next;
    logic        slot_first;
    logic        slot_last;

    // ****************************************
    // Slot decode
    // ****************************************
    // First rise of a slot latches, last rise closes it
    assign slot_first = rise & ~start_i & (phase_reg == 4'h0);
    assign slot_last  = rise & ~start_i
                      & (phase_reg == ratio_reg - 4'h1);

    // ****************************************
    // Mode latch
    // ****************************************
    always_comb
    begin
        ratio_next = ratio_reg;
        width_next = width_reg;
        if (start_i)
        begin
            ratio_next = ratio_of(width_sel_i, decomp_en_i,
                                  secure_en_i);
            width_next = width_sel_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ratio_reg <= RATIO_1;
            width_reg <= WIDTH_X8;
        end
        else
        begin
            ratio_reg <= ratio_next;
            width_reg <= width_next;
        end
    end

    // ****************************************
    // Slot phase
    // ****************************************
    always_comb
    begin
        phase_next = phase_reg;
        if (start_i)
        begin
            phase_next = 4'h0;
        end
        else if (slot_last)
        begin
            phase_next = 4'h0;
        end
        else if (rise)
        begin
            phase_next = phase_reg + 4'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase_reg <= 4'h0;
        end
        else
        begin
            phase_reg <= phase_next;
        end
    end

    // ****************************************
    // Word latch
    // ****************************************
    always_comb
    begin
        word_next  = word_reg;
        valid_next = 1'b0;
        if (slot_first)
        begin
            word_next  = dat_s2_reg & lane_mask(width_reg);
            valid_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            word_reg  <= 32'h0;
            valid_reg <= 1'b0;
        end
        else
        begin
            word_reg  <= word_next;
            valid_reg <= valid_next;
        end
    end

    // ****************************************
    // Processing flag
    // ****************************************
    // High while the extra clocks of a slot run
    always_comb
    begin
        busy_next = busy_reg;
        if (start_i || slot_last)
        begin
            busy_next = 1'b0;
        end
        else if (slot_first)
        begin
            busy_next = (ratio_reg != RATIO_1);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_reg <= 1'b0;
        end
        else
        begin
            busy_reg <= busy_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign word_o       = word_reg;
    assign word_valid_o = valid_reg;
    assign proc_busy_o  = busy_reg;

endmodule

// File: logic/passive_parallel_load_host.sv
module passive_parallel_load_host
    import ppl_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    ppl_if.host_mp           link,
    input  wire logic [1:0]  width_sel_i,
    input  wire logic        decomp_en_i,
    input  wire logic        secure_en_i,
    input  wire logic [31:0] word_i,
    input  wire logic        word_valid_i,
    output logic             word_ready_o,
    output logic             active_o
);

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01
    } host_state_t;

    host_state_t state_reg;
    host_state_t state_next;
    logic [3:0]  div_reg;
    logic [3:0]  div_next;
    logic        clk_reg;
    logic        clk_next;
    logic [3:0]  ratio_reg;
    logic [3:0]  ratio_next;
    logic [3:0]  cyc_reg;
    logic [3:0]  cyc_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    logic        rdy_reg;
    logic        rdy_next;
    logic        active_reg;
    logic        active_next;
    logic        fall;

    // ****************************************
    // Clock divider and word slots
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        div_next   = div_reg;
        clk_next   = clk_reg;
        ratio_next = ratio_reg;
        cyc_next   = cyc_reg;
        dat_next   = dat_reg;
        rdy_next   = 1'b0;
        fall       = 1'b0;
        if (state_reg != ST_IDLE)
        begin
            if (div_reg == HALF_CNT - 4'h1)
            begin
                div_next = 4'h0;
                clk_next = ~clk_reg;
                fall     = clk_reg;
            end
            else
            begin
                div_next = div_reg + 4'h1;
            end
        end
        case (state_reg)
            ST_IDLE:
            begin
                clk_next = 1'b0;
                div_next = 4'h0;
                if (word_valid_i)
                begin
                    ratio_next = ratio_of(width_sel_i, decomp_en_i,
                                          secure_en_i);
                    dat_next   = word_i & lane_mask(width_sel_i);
                    cyc_next   = 4'h0;
                    rdy_next   = 1'b1;
                    state_next = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (fall)
                begin
                    if (cyc_reg == ratio_reg - 4'h1)
                    begin
                        cyc_next = 4'h0;
                        if (word_valid_i)
                        begin
                            dat_next = word_i & lane_mask(width_sel_i);
                            rdy_next = 1'b1;
                        end
                        else
                        begin
                            // Slot clocks already cover the tail
                            state_next = ST_IDLE;
                        end
                    end
                    else
                    begin
                        cyc_next = cyc_reg + 4'h1;
                    end
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        active_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= ST_IDLE;
            div_reg   <= 4'h0;
            clk_reg   <= 1'b0;
            ratio_reg <= RATIO_1;
            cyc_reg   <= 4'h0;
            dat_reg   <= 32'h0;
            rdy_reg   <= 1'b0;
            active_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            div_reg   <= div_next;
            clk_reg   <= clk_next;
            ratio_reg <= ratio_next;
            cyc_reg   <= cyc_next;
            dat_reg   <= dat_next;
            rdy_reg   <= rdy_next;
            active_reg <= active_next;
        end
    end

    assign link.config_clock = clk_reg;
    assign link.cfg_data     = dat_reg;
    assign word_ready_o      = rdy_reg;
    assign active_o          = active_reg;

endmodule

// File: test/ppl_checker.sv
module ppl_checker
    import ppl_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        config_clock,
    input  wire logic [31:0] cfg_data,
    input  wire logic [1:0]  width_sel_i,
    input  wire logic        decomp_en_i,
    input  wire logic        secure_en_i
);
    logic [3:0] r_w;
    logic [3:0] phase_reg;
    logic [3:0] phase_next;
    logic [2:0] low_reg;
    logic [2:0] low_next;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ****************************************
    // Slot phase and idle tracking
    // ****************************************
    assign r_w = (width_sel_i == WIDTH_X32)
        ? (decomp_en_i ? RATIO_8 : (secure_en_i ? RATIO_4 : RATIO_1))
        : (width_sel_i == WIDTH_X16)
        ? (decomp_en_i ? RATIO_4 : (secure_en_i ? RATIO_2 : RATIO_1))
        : (decomp_en_i ? RATIO_2 : RATIO_1);

    always_comb
    begin
        low_next = config_clock ? 3'h0
                 : ((low_reg == 3'h7) ? low_reg : low_reg + 3'h1);
        phase_next = phase_reg;
        if (config_clock && low_reg != 3'h0)
            phase_next = (phase_reg + 4'h1 == r_w) ? 4'h0 : phase_reg + 4'h1;
        if (low_reg == 3'h7)
            phase_next = 4'h0;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            low_reg   <= 3'h0;
            phase_reg <= 4'h0;
        end
        else
        begin
            low_reg   <= low_next;
            phase_reg <= phase_next;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    clk_high_a: assert property (
        $rose(config_clock) |-> config_clock [*4] ##1 !config_clock)
        else $error("Config clock high time wrong");
    clk_low_a: assert property (
        $fell(config_clock) |-> (!config_clock) [*4])
        else $error("Config clock low time wrong");
    data_setup_a: assert property (
        config_clock |-> $stable(cfg_data))
        else $error("Data moved while clock high");
    data_hold_a: assert property (
        $fell(config_clock) |-> $stable(cfg_data) || phase_reg == r_w - 4'h1)
        else $error("Data moved at a fall inside a slot");
    slot_hold_a: assert property (
        $changed(cfg_data) |-> phase_reg == r_w - 4'h1 || low_reg == 3'h7)
        else $error("Data changed inside a slot");
    lane_x8_a: assert property (
        config_clock && width_sel_i == WIDTH_X8 |-> cfg_data[31:8] == 24'h0)
        else $error("Unused lanes driven in x8");
    lane_x16_a: assert property (
        config_clock && width_sel_i == WIDTH_X16 |-> cfg_data[31:16] == 16'h0)
        else $error("Unused lanes driven in x16");
    tail_count_a: assert property (
        low_reg == 3'h6 |-> phase_reg == r_w - 4'h1)
        else $error("Clock count per frame wrong");

    cover property ($rose(config_clock) && r_w == RATIO_8);
    cover property (low_reg == 3'h6 && r_w == RATIO_4);
    cover property ($changed(cfg_data) && width_sel_i == WIDTH_X8);
endmodule

// File: test/parallel_config_data_intake_tb.sv
module parallel_config_data_intake_tb
    import ppl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk;
    logic        rst_n;
    logic [1:0]  width_sel;
    logic        decomp_en;
    logic        secure_en;
    logic        start;
    logic [31:0] word_in;
    logic        word_valid;
    logic        word_ready;
    logic        active;
    logic [31:0] word_out;
    logic        word_valid_out;
    logic        busy;
    logic        busy_seen;
    logic        clk_prev;
    logic [31:0] got [4];
    int          bad_count;
    int          total_checks;
    int          rise_cnt;
    int          nwords;
    localparam logic [3:0] EXP_R [12] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h1,
        4'h2, 4'h4, 4'h4, 4'h1, 4'h4, 4'h8, 4'h8};

    ppl_if link_if ();

    passive_parallel_load_device passive_parallel_load_device_inst
    (
        .core_clk_i   (core_clk),
        .rst_n_i      (rst_n),
        .link         (link_if),
        .width_sel_i  (width_sel),
        .decomp_en_i  (decomp_en),
        .secure_en_i  (secure_en),
        .start_i      (start),
        .word_o       (word_out),
        .word_valid_o (word_valid_out),
        .proc_busy_o  (busy)
    );

    passive_parallel_load_host passive_parallel_load_host_inst
    (
        .core_clk_i   (core_clk),
        .rst_n_i      (rst_n),
        .link         (link_if),
        .width_sel_i  (width_sel),
        .decomp_en_i  (decomp_en),
        .secure_en_i  (secure_en),
        .word_i       (word_in),
        .word_valid_i (word_valid),
        .word_ready_o (word_ready),
        .active_o     (active)
    );

    ppl_checker ppl_checker_inst
    (
        .core_clk_i   (core_clk),
        .rst_n_i      (rst_n),
        .config_clock (link_if.config_clock),
        .cfg_data     (link_if.cfg_data),
        .width_sel_i  (width_sel),
        .decomp_en_i  (decomp_en),
        .secure_en_i  (secure_en)
    );

    // ****************************************
    // Clock and link monitor
    // ****************************************
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        clk_prev <= link_if.config_clock;
        if (link_if.config_clock === 1'b1 && clk_prev === 1'b0)
            rise_cnt <= rise_cnt + 1;
        if (word_valid_out === 1'b1)
        begin
            got[nwords[1:0]] <= word_out;
            nwords <= nwords + 1;
        end
        if (busy === 1'b1)
            busy_seen <= 1'b1;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("Checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic put_word(input logic [31:0] w);
        int n;
        n = 0;
        @(posedge core_clk);
        word_in <= w;
        word_valid <= 1'b1;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (word_ready !== 1'b1 && n < 200);
        check("word_ready", {31'h0, word_ready}, 32'h1);
    endtask

    task automatic run_mode(input int idx);
        logic [31:0] w0;
        logic [31:0] m;
        int          r;
        int          n;
        r = int'(EXP_R[idx]);
        m = (idx < 4) ? MASK_X8 : ((idx < 8) ? MASK_X16 : MASK_X32);
        w0 = 32'h8e3c_51a7 ^ 32'(idx);
        n = 0;
        @(posedge core_clk);
        width_sel <= 2'(idx / 4);
        decomp_en <= idx[1];
        secure_en <= idx[0];
        rise_cnt <= 0;
        nwords <= 0;
        busy_seen <= 1'b0;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        put_word(w0);
        put_word(~w0);
        @(posedge core_clk);
        word_valid <= 1'b0;
        while (active !== 1'b0 && n < 400)
        begin
            @(posedge core_clk);
            n++;
        end
        repeat (10) @(posedge core_clk);
        check("rises", 32'(rise_cnt), 32'(2 * r));
        check("words", 32'(nwords), 32'h2);
        check("word0", got[0], w0 & m);
        check("word1", got[1], ~w0 & m);
        check("busy", {31'h0, busy_seen}, {31'h0, r > 1});
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        width_sel = WIDTH_X8;
        decomp_en = 1'b0;
        secure_en = 1'b0;
        start = 1'b0;
        word_in = 32'h0;
        word_valid = 1'b0;
        rst_n = 1'b0;
        bad_count = 0;
        total_checks = 0;
        rise_cnt = 0;
        nwords = 0;
        busy_seen = 1'b0;
        clk_prev = 1'b0;
        repeat (3) @(posedge core_clk);
        check("reset_word", word_out, 32'h0);
        rst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        for (int i = 0; i < 12; i++)
            run_mode(i);
        complete_run();
    end

    initial
    begin
        #(20000 * 50);
        bad_count++;
        complete_run();
    end
endmodule
